// *** adc_averager.v ***
// Per channel converter averaging with start gating
`default_nettype none
`include "pse_policy_consts.vh"
module adc_averager #(
	parameter integer SAMPLE_W = 14,
	parameter integer START_CYC = 10000000
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Channel state
	input wire detecting,
	input wire powered,
	// Samples
	input wire sample_valid,
	input wire [SAMPLE_W-1:0] sample,
	// Result
	output reg result_valid,
	output reg [SAMPLE_W-1:0] result,
	output reg conv_enable
);
	reg [31:0] start_cnt;
	reg [SAMPLE_W+3:0] acc;
	reg [3:0] n;
	wire take = sample_valid && (detecting || (powered && conv_enable));
	wire [SAMPLE_W+3:0] sum = acc + {4'h0, sample};
	// Start timer gates conversions once powered
	always @(posedge ref_clk) begin
		if (sys_rst || !powered) begin
			start_cnt <= 32'h00000000;
			conv_enable <= 1'b0;
		end else if (start_cnt >= START_CYC[31:0] - 32'h00000001)
			conv_enable <= 1'b1;
		else
			start_cnt <= start_cnt + 32'h00000001;
	end
	// Sixteen sample average, continuous while powered
	always @(posedge ref_clk) begin
		if (sys_rst || !(detecting || powered)) begin
			acc <= {(SAMPLE_W+4){1'b0}};
			n <= 4'h0;
			result_valid <= 1'b0;
			result <= {SAMPLE_W{1'b0}};
		end else begin
			result_valid <= 1'b0;
			if (take) begin
				n <= n + 4'h1;
				if (n == 4'hF) begin
					result <= sum[SAMPLE_W+3:4];
					result_valid <= 1'b1;
					acc <= {(SAMPLE_W+4){1'b0}};
				end else
					acc <= sum;
			end
		end
	end
endmodule // adc_averager
`default_nettype wire

// *** policy_monitor.sv ***
// Port-level checker for the port policy control block
`default_nettype none
module policy_monitor #(
	parameter integer WD_CYC = 1000,
	parameter [6:0] DEVICE_BUS_ADDRESS = 7'h20
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Register access
	input wire logic [6:0] bus_address,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic bus_if_reset,
	// Pins and channel side
	input wire logic scl_in,
	input wire logic type3_config,
	input wire logic [7:0] channel_powered,
	input wire logic [7:0] double_foldback_select,
	input wire logic [3:0] assigned_class_odd,
	input wire logic [3:0] assigned_class_even,
	input wire logic [2:0] finger_count,
	input wire logic [7:0] conv_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic scl_q;
	logic [31:0] quiet;

	// Cycles since the bus clock pin last moved
	always @(posedge ref_clk) begin
		scl_q <= scl_in;
		if (sys_rst || scl_in != scl_q)
			quiet <= 32'h0;
		else if (quiet != 32'hFFFFFFFF)
			quiet <= quiet + 32'h1;
	end

	sequence fb_write;
		reg_wr && reg_ack && reg_addr == 8'h40;
	endsequence
	sequence powered_rise;
		$rose(channel_powered[0]);
	endsequence

	a_own_addr_ack:
		assert property ((reg_wr || reg_rd) &&
			bus_address == DEVICE_BUS_ADDRESS |-> reg_ack)
		else $error("own address not acknowledged");
	a_bcast_ack:
		assert property (reg_wr && bus_address == 7'h7F |-> reg_ack)
		else $error("broadcast write not acknowledged");
	a_ack_needs_strobe:
		assert property (reg_ack |-> reg_wr || reg_rd)
		else $error("ack without strobe");
	a_foldback_write:
		assert property (fb_write |=>
			double_foldback_select == $past(reg_wdata))
		else $error("foldback select not written");
	a_finger_legal:
		assert property (finger_count inside {3'h1, 3'h3, 3'h4, 3'h5})
		else $error("illegal finger count");
	a_type3_cap:
		assert property (type3_config [*3] |->
			assigned_class_odd <= 4'h4 && assigned_class_even <= 4'h4)
		else $error("pairset above class 4 in type 3");
	a_wd_single_pulse:
		assert property (bus_if_reset |=> !bus_if_reset)
		else $error("bus reset longer than one cycle");
	a_wd_needs_silence:
		assert property (bus_if_reset |-> quiet >= WD_CYC / 2)
		else $error("bus reset without clock silence");
	a_start_gate:
		assert property (powered_rise |-> (!conv_enable[0]) [*8])
		else $error("conversion before start timer");
endmodule // policy_monitor
`default_nettype wire

// *** pse_policy_consts.vh ***
// Constants for the port policy control block
`ifndef PSE_POLICY_CONSTS_VH
`define PSE_POLICY_CONSTS_VH
// Register offsets
`define OFS_PORT_PRIORITY_BITS 8'h15
`define OFS_GENERAL_MASK 8'h17
`define OFS_DEVICE_RESET_COMMAND 8'h1A
`define OFS_PORT_CHANNEL_MAP 8'h26
`define OFS_MULTILEVEL_PRIORITY_LOW 8'h27
`define OFS_MULTILEVEL_PRIORITY_HIGH 8'h28
`define OFS_POWER_ALLOCATION 8'h29
`define OFS_FOLDBACK_SELECT 8'h40
`define OFS_WATCHDOG 8'h1D
`define OFS_PORT_MODE 8'h12
`define OFS_POLICY_STATUS 8'h50
`define OFS_PORT_CHANNEL_MAP_HIGH 8'h51
// Field positions
`define BIT_PRIORITY_MODE_SELECT 7
`define BIT_WATCHDOG_STATUS_LOCATION 0
`define WD_DISABLE_LSB 1
// Reset values
`define RST_PORT_CHANNEL_MAP 16'hE4E4
`define RST_WD_DISABLE 4'hB
`define RST_POWER_ALLOCATION 8'hFF
`define RST_BYTE 8'h00
// Broadcast bus address
`define GLOBAL_BUS_ADDRESS 7'h7F
// Power allocation codes per 4-pair port nibble
`define ALLOC_15W 3'h0
`define ALLOC_30W 3'h1
`define ALLOC_45W 3'h2
`define ALLOC_60W 3'h3
`define ALLOC_75W 3'h4
`define ALLOC_90W 3'h5
// Class codes
`define CLASS_NONE 4'h0
`define CLASS_3 4'h3
`define CLASS_4 4'h4
`define CLASS_5D 4'hD
// Timing figures
`define CLK_FREQ_HZ 100000000
`define DEGLITCH_NS 5000
`define SHUTDOWN_BIT_NS 10000
`define IDLE_MIN_NS 200000
`define WD_TIMEOUT_MS 2000
`define START_TIMER_MS 100
`define DETECT_SAMPLES 16
`endif

// *** pse_port_policy_control.v ***
// Port policy control: priority shutdown, remap, watchdog, demotion
`default_nettype none
`include "pse_policy_consts.vh"
// How it works
// - Type-3 setting caps any one dual-signature pairset at Class 4.
// - Dual-signature classes of port 1 follow allocation demotion table.
// - X-D load is evaluated as class X on each pairset.
// - Writes at broadcast bus address are accepted.
// - Logical ports remap only within group 1-4 or group 5-8.
// - Remap write dropped unless all four group ports are off.
// - Invalid remap code keeps previous mapping; readback shows it.
// - Remap survives software reset; pin or power reset restores default.
// - Priority mode bit in general mask picks 1-bit or 3-bit.
// - 1-bit mode: shutdown high turns off low-priority ports.
// - 3-bit mode: per-port code, 000 highest, eight levels.
// - 3-bit mode: ports with code >= received code are disabled.
// - Shutdown input deglitched; longer pulse from idle is start bit.
// - Clock-line silence for timeout latches ports off, sets flag.
// - Flag sets even when disabled; clears by reset or zero write.
// - Disable field pattern 1011b blocks only bus_if_reset, not port latch-off; preset at power-up.
// - Detection results average sixteen converter samples.
// - Powered conversions wait for start timer, then run continuously.
// - After power good, select bit picks double or single foldback.
// - Allocation caps classification fingers: 1,3,4,5 by power.
module pse_port_policy_control #(
	parameter integer WD_CYC = `WD_TIMEOUT_MS * 100000,
	parameter integer START_CYC = `START_TIMER_MS * 100000,
	parameter [6:0] DEVICE_BUS_ADDRESS = 7'h20,
	parameter integer SAMPLE_W = 14
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Register access from bus interface
	input wire [6:0] bus_address,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output wire reg_ack,
	output reg bus_if_reset,
	// Pins from outside
	input wire scl_in,
	input wire shutdown_input,
	// Channel state and converter
	input wire [7:0] power_good,
	input wire [7:0] channel_powered,
	input wire [7:0] channel_detecting,
	input wire [7:0] dual_signature,
	input wire [3:0] requested_class_odd,
	input wire type3_config,
	input wire [7:0] sample_valid,
	input wire [8*SAMPLE_W-1:0] samples,
	// Outputs to channels
	output reg [7:0] port_off,
	output reg [7:0] double_foldback_select,
	output reg [3:0] assigned_class_odd,
	output reg [3:0] assigned_class_even,
	output reg [2:0] finger_count,
	output wire [7:0] avg_valid,
	output wire [8*SAMPLE_W-1:0] avg_result,
	output wire [7:0] conv_enable
);
	localparam integer IDLE_CYC = `IDLE_MIN_NS / 10;
	reg [7:0] port_priority_bits;
	reg [7:0] general_mask;
	reg [15:0] port_channel_map;
	reg [7:0] multilevel_priority_low;
	reg [7:0] multilevel_priority_high;
	reg [7:0] power_allocation;
	reg [7:0] port_mode;
	reg [3:0] wd_disable;
	reg watchdog_status_flag;
	reg [1:0] scl_s, sh_s;
	reg scl_prev;
	reg [31:0] wd_cnt;
	reg wd_expire;
	wire sh_level, code_valid;
	wire [2:0] sh_code;
	wire addr_ok = (bus_address == DEVICE_BUS_ADDRESS) ||
		(bus_address == `GLOBAL_BUS_ADDRESS);
	wire wr = reg_wr && addr_ok;
	wire wd_enabled = (wd_disable != `RST_WD_DISABLE);
	wire mbit = general_mask[`BIT_PRIORITY_MODE_SELECT];
	assign reg_ack = (reg_wr || reg_rd) && addr_ok;
	// Pin synchronisers
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			scl_s <= 2'b11;
			sh_s <= 2'b00;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sh_s <= {sh_s[0], shutdown_input};
		end
	end
	shutdown_receiver u_rx (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.shutdown_sync(sh_s[1]),
		.level_high(sh_level),
		.code_valid(code_valid),
		.code(sh_code)
	);
	// Remap validity: each group's four codes must be a permutation
	function map_ok;
		input [7:0] m;
		reg [3:0] seen;
		begin
			seen = 4'h0;
			seen[m[1:0]] = 1'b1;
			seen[m[3:2]] = 1'b1;
			seen[m[5:4]] = 1'b1;
			seen[m[7:6]] = 1'b1;
			map_ok = (seen == 4'hF);
		end
	endfunction
	// Register writes; software reset command leaves map alone
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			port_priority_bits <= `RST_BYTE;
			general_mask <= `RST_BYTE;
			port_channel_map <= `RST_PORT_CHANNEL_MAP;
			multilevel_priority_low <= `RST_BYTE;
			multilevel_priority_high <= `RST_BYTE;
			power_allocation <= `RST_POWER_ALLOCATION;
			double_foldback_select <= `RST_BYTE;
			port_mode <= `RST_BYTE;
			wd_disable <= `RST_WD_DISABLE;
		end else if (wr) begin
			if (reg_addr == `OFS_PORT_PRIORITY_BITS)
				port_priority_bits <= reg_wdata;
			else if (reg_addr == `OFS_GENERAL_MASK)
				general_mask <= reg_wdata;
			else if (reg_addr == `OFS_DEVICE_RESET_COMMAND) begin
				port_priority_bits <= `RST_BYTE;
				general_mask <= `RST_BYTE;
				multilevel_priority_low <= `RST_BYTE;
				multilevel_priority_high <= `RST_BYTE;
				power_allocation <= `RST_POWER_ALLOCATION;
				double_foldback_select <= `RST_BYTE;
				port_mode <= `RST_BYTE;
			end else if (reg_addr == `OFS_PORT_CHANNEL_MAP) begin
				// Low byte group 1-4, high byte group 5-8
				if (port_mode[3:0] == 4'h0 && map_ok(reg_wdata))
					port_channel_map[7:0] <= reg_wdata;
			end else if (reg_addr == `OFS_PORT_CHANNEL_MAP_HIGH) begin
				if (port_mode[7:4] == 4'h0 && map_ok(reg_wdata))
					port_channel_map[15:8] <= reg_wdata;
			end else if (reg_addr == `OFS_MULTILEVEL_PRIORITY_LOW)
				multilevel_priority_low <= reg_wdata;
			else if (reg_addr == `OFS_MULTILEVEL_PRIORITY_HIGH)
				multilevel_priority_high <= reg_wdata;
			else if (reg_addr == `OFS_POWER_ALLOCATION)
				power_allocation <= reg_wdata;
			else if (reg_addr == `OFS_FOLDBACK_SELECT)
				double_foldback_select <= reg_wdata;
			else if (reg_addr == `OFS_PORT_MODE)
				port_mode <= reg_wdata;
			else if (reg_addr == `OFS_WATCHDOG)
				wd_disable <= reg_wdata[`WD_DISABLE_LSB+3:`WD_DISABLE_LSB];
		end
	end
	// Register readback; unmapped reads zero
	always @* begin
		reg_rdata = 8'h00;
		if (reg_addr == `OFS_PORT_PRIORITY_BITS)
			reg_rdata = port_priority_bits;
		else if (reg_addr == `OFS_GENERAL_MASK)
			reg_rdata = general_mask;
		else if (reg_addr == `OFS_PORT_CHANNEL_MAP)
			reg_rdata = port_channel_map[7:0];
		else if (reg_addr == `OFS_PORT_CHANNEL_MAP_HIGH)
			reg_rdata = port_channel_map[15:8];
		else if (reg_addr == `OFS_MULTILEVEL_PRIORITY_LOW)
			reg_rdata = multilevel_priority_low;
		else if (reg_addr == `OFS_MULTILEVEL_PRIORITY_HIGH)
			reg_rdata = multilevel_priority_high;
		else if (reg_addr == `OFS_POWER_ALLOCATION)
			reg_rdata = power_allocation;
		else if (reg_addr == `OFS_FOLDBACK_SELECT)
			reg_rdata = double_foldback_select;
		else if (reg_addr == `OFS_PORT_MODE)
			reg_rdata = port_mode;
		else if (reg_addr == `OFS_WATCHDOG)
			reg_rdata = {3'h0, wd_disable, watchdog_status_flag};
		else if (reg_addr == `OFS_POLICY_STATUS)
			reg_rdata = port_off;
	end
	// Bus watchdog: count clock-line silence
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			scl_prev <= 1'b1;
			wd_cnt <= 32'h00000000;
			wd_expire <= 1'b0;
		end else begin
			scl_prev <= scl_s[1];
			wd_expire <= 1'b0;
			if (scl_prev != scl_s[1])
				wd_cnt <= 32'h00000000;
			else if (wd_cnt == WD_CYC[31:0] - 32'h00000001) begin
				wd_cnt <= 32'h00000000;
				wd_expire <= 1'b1;
			end else
				wd_cnt <= wd_cnt + 32'h00000001;
		end
	end
	// Watchdog flag: set wins over software clear
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			watchdog_status_flag <= 1'b0;
			bus_if_reset <= 1'b0;
		end else begin
			bus_if_reset <= wd_expire && wd_enabled;
			if (wd_expire)
				watchdog_status_flag <= 1'b1;
			else if (wr && reg_addr == `OFS_WATCHDOG &&
				!reg_wdata[`BIT_WATCHDOG_STATUS_LOCATION])
				watchdog_status_flag <= 1'b0;
		end
	end
	// Shutdown decisions; latch off until port mode rewritten
	integer p;
	reg [7:0] next_port_off;
	// One 3-bit code per nibble, one nibble per 4-pair port
	wire [15:0] mlvl = {multilevel_priority_high, multilevel_priority_low};
	always @* begin
		next_port_off = port_off;
		if (wd_expire)
			next_port_off = 8'hFF;
		for (p = 0; p < 8; p = p + 1) begin
			if (!mbit && sh_level && port_priority_bits[p])
				next_port_off[p] = 1'b1;
			// Both channels of a port share its code
			if (mbit && code_valid && mlvl[(p/2)*4 +: 3] >= sh_code)
				next_port_off[p] = 1'b1;
		end
		if (wr && reg_addr == `OFS_PORT_MODE)
			next_port_off = 8'h00;
	end
	always @(posedge ref_clk) begin
		if (sys_rst)
			port_off <= 8'h00;
		else
			port_off <= next_port_off;
	end
	// Dual signature demotion and finger cap, port 1 pair
	wire [2:0] alloc = power_allocation[2:0];
	reg [3:0] pd_cls;
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			assigned_class_odd <= `CLASS_NONE;
			assigned_class_even <= `CLASS_NONE;
			finger_count <= 3'h1;
			pd_cls <= `CLASS_3;
		end else begin
			pd_cls <= requested_class_odd;
			finger_count <= (alloc == `ALLOC_15W) ? 3'h1 :
				(alloc == `ALLOC_30W || alloc == `ALLOC_45W) ? 3'h3 :
				(alloc == `ALLOC_90W) ? 3'h5 : 3'h4;
			if (!dual_signature[0]) begin
				assigned_class_odd <= pd_cls;
				assigned_class_even <= pd_cls;
			end else if (alloc == `ALLOC_15W) begin
				assigned_class_odd <= `CLASS_3;
				assigned_class_even <= `CLASS_NONE;
			end else if (pd_cls == `CLASS_3) begin
				assigned_class_odd <= `CLASS_3;
				assigned_class_even <= `CLASS_3;
			end else if (alloc == `ALLOC_30W) begin
				assigned_class_odd <= `CLASS_4;
				assigned_class_even <= `CLASS_NONE;
			end else if (alloc == `ALLOC_45W) begin
				assigned_class_odd <= `CLASS_4;
				assigned_class_even <= `CLASS_3;
			end else if (pd_cls == `CLASS_4 || alloc == `ALLOC_60W ||
				type3_config) begin
				assigned_class_odd <= `CLASS_4;
				assigned_class_even <= `CLASS_4;
			end else if (alloc == `ALLOC_75W) begin
				assigned_class_odd <= `CLASS_5D;
				assigned_class_even <= `CLASS_4;
			end else begin
				assigned_class_odd <= `CLASS_5D;
				assigned_class_even <= `CLASS_5D;
			end
		end
	end
	// Per channel averaging and start gating
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : ch
			adc_averager #(
				.SAMPLE_W(SAMPLE_W),
				.START_CYC(START_CYC)
			) u_avg (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.detecting(channel_detecting[g]),
				.powered(channel_powered[g] && power_good[g]),
				.sample_valid(sample_valid[g]),
				.sample(samples[g*SAMPLE_W +: SAMPLE_W]),
				.result_valid(avg_valid[g]),
				.result(avg_result[g*SAMPLE_W +: SAMPLE_W]),
				.conv_enable(conv_enable[g])
			);
		end
	endgenerate
endmodule // pse_port_policy_control
`default_nettype wire

// *** shutdown_driver.sv ***
// Far-side model: shutdown line driver and bus clock source
`default_nettype none
module shutdown_driver #(
	parameter integer BIT_NS = 10000
) (
	// Pins toward the block
	output logic shutdown_input,
	output logic scl_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_run = 1'b1;

	// -----------------------------
	// Bus clock, 80 ns, stops on demand
	// -----------------------------
	initial begin
		shutdown_input = 1'b0;
		scl_in = 1'b1;
		forever begin
			#40;
			if (scl_run)
				scl_in = ~scl_in;
		end
	end

	// Single level pulse, idle low afterwards
	task automatic pulse(input integer ns);
		shutdown_input = 1'b1;
		#(ns);
		shutdown_input = 1'b0;
	endtask

	// Start bit longer than the filter, then code MSB first
	task automatic send_code(input logic [2:0] c);
		integer b;
		shutdown_input = 1'b1;
		#(BIT_NS);
		for (b = 2; b >= 0; b--) begin
			shutdown_input = c[b];
			#(BIT_NS);
		end
		shutdown_input = 1'b0;
	endtask
endmodule // shutdown_driver
`default_nettype wire

// *** shutdown_receiver.v ***
// Deglitch and serial code receiver for the shutdown input
`default_nettype none
`include "pse_policy_consts.vh"
module shutdown_receiver #(
	parameter integer DEGLITCH_CYC = (`DEGLITCH_NS + 9) / 10,
	parameter integer BIT_CYC = `SHUTDOWN_BIT_NS / 10
) (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Synchronised input
	input wire shutdown_sync,
	// Results
	output reg level_high,
	output reg code_valid,
	output reg [2:0] code
);
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_START = 4'b0010;
	localparam [3:0] ST_BITS = 4'b0100;
	localparam [3:0] ST_WAIT = 4'b1000;
	reg [3:0] state;
	reg [15:0] filt_cnt;
	reg [15:0] bit_cnt;
	reg [1:0] bit_idx;
	reg [2:0] shift;
	reg filt_prev;
	// Deglitch filter: level taken only after a stable run
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			filt_cnt <= 16'h0000;
			level_high <= 1'b0;
			filt_prev <= 1'b0;
		end else begin
			filt_prev <= shutdown_sync;
			if (shutdown_sync != filt_prev)
				filt_cnt <= 16'h0000;
			else if (filt_cnt >= DEGLITCH_CYC[15:0] - 16'h0001)
				level_high <= shutdown_sync;
			else
				filt_cnt <= filt_cnt + 16'h0001;
		end
	end
	// Frame receiver: start bit then three code bits, MSB first
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			bit_cnt <= 16'h0000;
			bit_idx <= 2'h0;
			shift <= 3'h0;
			code_valid <= 1'b0;
			code <= 3'h0;
		end else begin
			code_valid <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (level_high) begin
					state <= ST_START;
					bit_cnt <= 16'h0000;
				end
			end
			ST_START: begin
				bit_cnt <= bit_cnt + 16'h0001;
				if (bit_cnt == BIT_CYC[15:0] + BIT_CYC[15:0] / 16'h0002) begin
					state <= ST_BITS;
					bit_cnt <= 16'h0000;
					bit_idx <= 2'h0;
					shift <= {shift[1:0], level_high};
				end
			end
			ST_BITS: begin
				bit_cnt <= bit_cnt + 16'h0001;
				if (bit_cnt == BIT_CYC[15:0] - 16'h0001) begin
					bit_cnt <= 16'h0000;
					shift <= {shift[1:0], level_high};
					bit_idx <= bit_idx + 2'h1;
					if (bit_idx == 2'h1) begin
						state <= ST_WAIT;
						code <= {shift[1:0], level_high};
						code_valid <= 1'b1;
					end
				end
			end
			ST_WAIT: begin
				if (!level_high)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // shutdown_receiver
`default_nettype wire

// *** tb.sv ***
// Testbench for the port policy control block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam integer SW = 14;
	localparam [6:0] DEV = 7'h20;
	logic ref_clk, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, k;
	logic type3_config = 1'b0;
	logic [6:0] bus_address = DEV;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, q;
	logic [7:0] power_good = 8'h00, channel_powered = 8'h00;
	logic [7:0] channel_detecting = 8'h00, dual_signature = 8'h00;
	logic [7:0] sample_valid = 8'h00;
	logic [3:0] requested_class_odd = 4'h0;
	logic [8*SW-1:0] samples = '0;
	logic [19:0] dm [5] = '{20'hD5ADD, 20'hD40D4, 20'hD0230,
		20'hD5144, 20'h43844};
	wire logic shutdown_input, scl_in, reg_ack, bus_if_reset;
	wire logic [7:0] reg_rdata, port_off, double_foldback_select;
	wire logic [7:0] avg_valid, conv_enable;
	wire logic [3:0] assigned_class_odd, assigned_class_even;
	wire logic [2:0] finger_count;
	wire logic [8*SW-1:0] avg_result;
	integer num_errors = 0, n_compared = 0, i;

	pse_port_policy_control #(.WD_CYC(1000), .START_CYC(100),
		.DEVICE_BUS_ADDRESS(DEV), .SAMPLE_W(SW)) DUT (
		.ref_clk, .sys_rst, .bus_address, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_ack, .bus_if_reset, .scl_in,
		.shutdown_input, .power_good, .channel_powered,
		.channel_detecting, .dual_signature, .requested_class_odd,
		.type3_config, .sample_valid, .samples, .port_off,
		.double_foldback_select, .assigned_class_odd,
		.assigned_class_even, .finger_count, .avg_valid, .avg_result,
		.conv_enable);
	shutdown_driver u_far (.shutdown_input, .scl_in);

	// --------------------
	// Clock and watchdog
	// --------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#600000;
		num_errors++;
		close_out();
	end

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input integer n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// One-cycle strobe, answer taken at the closing edge
	task automatic acc(input logic w, input logic [6:0] ba,
		input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		bus_address = ba;
		reg_wr = w;
		reg_rd = ~w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk);
		q = reg_rdata;
		k = reg_ack;
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, DEV, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, DEV, a, 8'h00);
		chk(16'(q), 16'(e));
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// --------------------
	// Test sequence
	// --------------------
	initial begin
		tick(5);
		sys_rst = 1'b0;
		// No memory image here, so traffic may start at once
		rd(8'h26, 8'hE4);
		rd(8'h1D, 8'h16);
		rd(8'h29, 8'hFF);
		$display("test reset values done");
		wr(8'h12, 8'h01);
		wr(8'h26, 8'h39);
		rd(8'h26, 8'hE4);
		wr(8'h51, 8'h1B);
		rd(8'h51, 8'h1B);
		wr(8'h12, 8'h00);
		wr(8'h26, 8'h39);
		rd(8'h26, 8'h39);
		acc(1'b1, DEV, 8'h26, 8'h00);
		chk(16'(k), 16'h1);
		rd(8'h26, 8'h39);
		acc(1'b1, 7'h7F, 8'h40, 8'h5A);
		chk(16'(k), 16'h1);
		acc(1'b1, 7'h10, 8'h40, 8'h00);
		chk(16'(k), 16'h0);
		tick(1);
		chk(16'(double_foldback_select), 16'h5A);
		wr(8'h1A, 8'h01);
		rd(8'h26, 8'h39);
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		rd(8'h26, 8'hE4);
		rd(8'h51, 8'hE4);
		$display("test remap done");
		wr(8'h15, 8'hA5);
		u_far.pulse(500);
		tick(600);
		chk(16'(port_off), 16'h0);
		u_far.pulse(8000);
		tick(10);
		chk(16'(port_off), 16'hA5);
		$display("test single-bit shutdown done");
		tick(20100); // Line idle low before the mode change
		wr(8'h12, 8'h00);
		wr(8'h17, 8'h80);
		wr(8'h27, 8'h42); // One code serves both channels
		wr(8'h28, 8'h61);
		u_far.send_code(3'h5);
		tick(2000);
		chk(16'(port_off), 16'hC0);
		wr(8'h12, 8'h00);
		u_far.send_code(3'h2);
		tick(2000);
		chk(16'(port_off), 16'hCF);
		wr(8'h12, 8'h00);
		u_far.send_code(3'h0);
		tick(2000);
		chk(16'(port_off), 16'hFF);
		wr(8'h12, 8'h00);
		$display("test three-bit shutdown done");
		channel_detecting = 8'hFF;
		for (i = 0; i < 16; i++) begin
			samples = {8{i[0] ? 14'h0120 : 14'h0100}};
			sample_valid = 8'hFF;
			tick(1);
			if (i == 15)
				chk(16'(avg_valid), 16'h00FF);
			sample_valid = 8'h00;
			tick(1);
		end
		tick(20);
		chk(16'(avg_result[SW-1:0]), 16'h0110);
		chk(16'(avg_result[8*SW-1 -: SW]), 16'h0110);
		channel_detecting = 8'h00;
		power_good = 8'hFF;
		channel_powered = 8'hFF;
		tick(50);
		chk(16'(conv_enable), 16'h0);
		tick(80);
		chk(16'(conv_enable), 16'h00FF);
		$display("test converter done");
		dual_signature = 8'hFF;
		// Request, allocation, fingers and type, odd and even class
		for (i = 0; i < 5; i++) begin
			requested_class_odd = dm[i][19:16];
			type3_config = dm[i][8];
			wr(8'h29, {dm[i][15:12], dm[i][15:12]});
			tick(4);
			chk(16'({assigned_class_odd, assigned_class_even}),
				16'(dm[i][7:0]));
			if (dm[i][11:9] != 3'h0)
				chk(16'(finger_count), 16'(dm[i][11:9]));
		end
		type3_config = 1'b0;
		$display("test demotion done");
		u_far.scl_run = 1'b0;
		tick(1200);
		rd(8'h1D, 8'h17);
		u_far.scl_run = 1'b1;
		tick(10);
		wr(8'h1D, 8'h00);
		wr(8'h12, 8'h00);
		rd(8'h1D, 8'h00);
		u_far.scl_run = 1'b0;
		for (i = 0; i < 1500 && bus_if_reset !== 1'b1; i++)
			tick(1);
		chk(16'(bus_if_reset), 16'h1);
		tick(2);
		chk(16'(port_off), 16'hFF);
		rd(8'h1D, 8'h01);
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		rd(8'h1D, 8'h16);
		$display("test watchdog done");
		close_out();
	end
endmodule // tb

bind pse_port_policy_control policy_monitor #(.WD_CYC(WD_CYC),
	.DEVICE_BUS_ADDRESS(DEVICE_BUS_ADDRESS)) u_mon (
	.ref_clk, .sys_rst, .bus_address, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_ack, .bus_if_reset, .scl_in, .type3_config,
	.channel_powered, .double_foldback_select, .assigned_class_odd,
	.assigned_class_even, .finger_count, .conv_enable);
`default_nettype wire
